// >>> core/tcw_top.sv
// Ternary match block with selectable register clocking and an Avalon register port
`default_nettype none
`include "tcw_regs.svh"

module tcw_top
    import tcw_pkg::*;
#(
    parameter int ENTRIES = `TCW_ENTRIES,
    parameter int WIDTH = `TCW_WIDTH,
    parameter int AW = $clog2(ENTRIES)
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dedicated_clock,
    input wire logic [3:0] global_clock_set,
    input wire logic global_reset,
    input wire logic local_reset,
    input wire logic [WIDTH-1:0] write_data,
    input wire logic [AW-1:0] write_address,
    input wire logic write_enable,
    input wire logic write_chip_select,
    input wire logic write_dont_care,
    input wire logic mask_enable,
    output logic [AW-1:0] match_address,
    output logic match_flag,
    output logic multi_match_flag
);

    typedef struct packed {
        tcw_bus_e bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [`TCW_CFG_BITS-1:0] cfg;
        logic [WIDTH-1:0] mask;
        logic src_prev;
        logic [WIDTH-1:0] cap_data;
        logic [AW-1:0] cap_addr;
        logic cap_we;
        logic cap_cs;
        logic cap_dc;
        logic cap_mask_en;
        logic cap_op;
        logic hit;
        logic multi;
        logic [AW-1:0] addr;
    } tcw_top_s;

    localparam tcw_top_s RESET_ST = '{
        bus: TCW_BUS_IDLE,
        waitreq: 1'b1,
        cfg: `TCW_CFG_RESET,
        default: '0
    };

    tcw_top_s st_r;
    tcw_top_s st_nxt;
    logic clk_raw;
    logic ce_raw;
    logic src_now;
    logic ce_val;
    logic act_tick;
    logic act_edge;
    logic shared_rst;
    logic out_reg;
    logic [ENTRIES-1:0] match_vec;
    logic hit_now;
    logic multi_now;
    logic [AW-1:0] addr_now;
    logic [63:0] mask64;
    logic [63:0] mask64_new;
    logic [31:0] rd_mux;

    // Lowest set index of a hit vector
    function automatic logic [AW-1:0] lowest_index(input logic [ENTRIES-1:0] v);
        logic [AW-1:0] r;
        r = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = AW'(i);
            end
        end
        return r;
    endfunction : lowest_index

    // Byte-lane merge for partial Avalon writes
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // Clock and clock-enable source selection; one pair serves inputs and outputs
    always_comb begin
        case (tcw_clk_src_e'(st_r.cfg[`TCW_CFG_CLK_SEL_LSB +: `TCW_CFG_CLK_SEL_BITS]))
            TCW_CLK_DEDICATED: clk_raw = dedicated_clock;
            TCW_CLK_GLOBAL0: clk_raw = global_clock_set[0];
            TCW_CLK_GLOBAL1: clk_raw = global_clock_set[1];
            TCW_CLK_GLOBAL2: clk_raw = global_clock_set[2];
            TCW_CLK_GLOBAL3: clk_raw = global_clock_set[3];
            default: clk_raw = dedicated_clock;
        endcase
        case (tcw_ce_src_e'(st_r.cfg[`TCW_CFG_CE_SEL_LSB +: `TCW_CFG_CE_SEL_BITS]))
            TCW_CE_WRITE_EN: ce_raw = write_enable;
            TCW_CE_GLOBAL1: ce_raw = global_clock_set[1];
            TCW_CE_GLOBAL2: ce_raw = global_clock_set[2];
            default: ce_raw = write_enable;
        endcase
    end

    // Selected clock is sampled, so an active edge needs it low and high for a cycle each
    assign src_now = clk_raw ^ st_r.cfg[`TCW_CFG_CLK_INV];
    assign ce_val = ce_raw ^ st_r.cfg[`TCW_CFG_CE_INV];
    assign act_tick = src_now & ~st_r.src_prev;
    assign act_edge = act_tick & ce_val;
    assign shared_rst = global_reset | (local_reset ^ st_r.cfg[`TCW_CFG_LRST_INV]);
    assign out_reg = st_r.cfg[`TCW_CFG_OUT_REG];

    // Result decode from the registered hit vector
    assign hit_now = |match_vec;
    assign multi_now = |(match_vec & (match_vec - ENTRIES'(1)));
    assign addr_now = lowest_index(match_vec);
    assign mask64 = 64'(st_r.mask);

    tcw_array #(
        .ENTRIES(ENTRIES),
        .WIDTH(WIDTH),
        .AW(AW)
    ) u_array (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .wr_en(st_r.cap_op & st_r.cap_we & st_r.cap_cs),
        .wr_addr(st_r.cap_addr),
        .wr_data(st_r.cap_data),
        .wr_dont_care(st_r.cap_dc),
        .mask_enable(st_r.cap_mask_en),
        .mask(st_r.mask),
        .key(st_r.cap_data),
        .match_vec(match_vec)
    );

    // Register read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (avs_address)
            `TCW_OFF_CONFIG: rd_mux = 32'(st_r.cfg);
            `TCW_OFF_MASK_LO: rd_mux = mask64[31:0];
            `TCW_OFF_MASK_HI: rd_mux = mask64[63:32];
            `TCW_OFF_STATUS: begin
                rd_mux[`TCW_ST_MATCH] = st_r.hit;
                rd_mux[`TCW_ST_MULTI] = st_r.multi;
                rd_mux[`TCW_ST_ADDR_LSB +: AW] = st_r.addr;
            end
            default: rd_mux = '0;
        endcase
    end

    // Bus sequencer, capture path and result registers
    always_comb begin
        st_nxt = st_r;
        mask64_new = {be_merge(mask64[63:32], avs_writedata, avs_byteenable),
                      be_merge(mask64[31:0], avs_writedata, avs_byteenable)};
        // Every access takes one wait cycle; write lands when waitrequest is seen low
        case (st_r.bus)
            TCW_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    st_nxt.bus = TCW_BUS_ANSWER;
                    st_nxt.waitreq = 1'b0;
                    st_nxt.rdata = avs_read ? rd_mux : '0;
                end
            end
            TCW_BUS_ANSWER: begin
                st_nxt.bus = TCW_BUS_IDLE;
                st_nxt.waitreq = 1'b1;
                if (avs_write) begin
                    case (avs_address)
                        `TCW_OFF_CONFIG: st_nxt.cfg = `TCW_CFG_BITS'(be_merge(32'(st_r.cfg), avs_writedata,
                                                                           avs_byteenable));
                        `TCW_OFF_MASK_LO: st_nxt.mask = WIDTH'({mask64[63:32], mask64_new[31:0]});
                        `TCW_OFF_MASK_HI: st_nxt.mask = WIDTH'({mask64_new[63:32], mask64[31:0]});
                        default: st_nxt.cfg = st_r.cfg;
                    endcase
                end
            end
            default: begin
                st_nxt.bus = TCW_BUS_IDLE;
                st_nxt.waitreq = 1'b1;
            end
        endcase
        st_nxt.src_prev = src_now;
        st_nxt.cap_op = 1'b0;
        if (shared_rst) begin
            // One reset for both register banks
            st_nxt.cap_data = '0;
            st_nxt.cap_addr = '0;
            st_nxt.cap_we = 1'b0;
            st_nxt.cap_cs = 1'b0;
            st_nxt.cap_dc = 1'b0;
            st_nxt.cap_mask_en = 1'b0;
            st_nxt.hit = 1'b0;
            st_nxt.multi = 1'b0;
            st_nxt.addr = '0;
        end else begin
            if (act_edge) begin
                st_nxt.cap_data = write_data;
                st_nxt.cap_addr = write_address;
                st_nxt.cap_we = write_enable;
                st_nxt.cap_cs = write_chip_select;
                st_nxt.cap_dc = write_dont_care;
                // Taken straight at the edge; the user must hold it stable there
                st_nxt.cap_mask_en = mask_enable;
                st_nxt.cap_op = 1'b1;
            end
            // Combinational mode still passes one flop so outputs stay glitch free
            if (out_reg ? act_edge : 1'b1) begin
                st_nxt.hit = hit_now;
                st_nxt.multi = multi_now;
                st_nxt.addr = addr_now;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= RESET_ST;
        end else if (clock_enable) begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    assign match_address = st_r.addr;
    assign match_flag = st_r.hit;
    assign multi_match_flag = st_r.multi;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_ded_low;
        clock_enable && st_r.cfg[`TCW_CFG_CLK_SEL_LSB +: `TCW_CFG_CLK_SEL_BITS] == TCW_CLK_DEDICATED
        && !st_r.cfg[`TCW_CFG_CLK_INV] && !dedicated_clock;
    endsequence

    sequence s_ded_high;
        dedicated_clock && $stable(st_r.cfg);
    endsequence

    sequence s_reg_capture;
        clock_enable && out_reg && act_edge && !shared_rst;
    endsequence

    a_input_capture: assert property (
        clock_enable && act_edge && !shared_rst
        |=> st_r.cap_data == $past(write_data) && st_r.cap_addr == $past(write_address) && st_r.cap_op)
        else $error("inputs not captured on the active edge");

    a_inputs_hold: assert property (
        clock_enable && !act_edge && !shared_rst |=> $stable(st_r.cap_data) && !st_r.cap_op)
        else $error("input registers moved without a qualified edge");

    a_reg_out_hold: assert property (
        clock_enable && out_reg && !act_edge && !shared_rst
        |=> $stable(match_address) && $stable(match_flag) && $stable(multi_match_flag))
        else $error("registered outputs moved without a qualified edge");

    a_reg_out_load: assert property (
        s_reg_capture |=> match_flag == $past(hit_now) && match_address == $past(addr_now))
        else $error("registered results not loaded at the active edge");

    a_comb_follow: assert property (
        clock_enable && !out_reg && !shared_rst |=> match_flag == $past(hit_now) && multi_match_flag == $past(multi_now))
        else $error("combinational results did not follow the compare");

    a_shared_reset_clear: assert property (
        clock_enable && shared_rst
        |=> !match_flag && !multi_match_flag && match_address == '0 && !st_r.cap_op && st_r.cap_data == '0)
        else $error("shared reset left a register set");

    a_local_reset_pol: assert property (
        clock_enable && (local_reset != st_r.cfg[`TCW_CFG_LRST_INV]) && act_edge |=> !st_r.cap_op)
        else $error("asserted local reset did not block a capture");

    a_dedicated_edge: assert property (
        s_ded_low ##1 s_ded_high |-> act_tick)
        else $error("rising dedicated clock gave no active edge");

    a_ce_select: assert property (
        act_tick && st_r.cfg[`TCW_CFG_CE_SEL_LSB +: `TCW_CFG_CE_SEL_BITS] == TCW_CE_WRITE_EN
        && !st_r.cfg[`TCW_CFG_CE_INV] && !write_enable |-> !act_edge)
        else $error("edge qualified while write enable was low");

    a_multi_hit: assert property (
        multi_match_flag |-> match_flag)
        else $error("multi-match without match");

endmodule : tcw_top

`default_nettype wire

// >>> shared/tcw_regs.svh
// Register offsets, field positions, reset values and sizes of the ternary match block
`ifndef TCW_REGS_SVH
`define TCW_REGS_SVH

// Array geometry
`define TCW_ENTRIES 128
`define TCW_WIDTH 48

// Avalon byte offsets of the register words
`define TCW_OFF_CONFIG 4'h0
`define TCW_OFF_MASK_LO 4'h4
`define TCW_OFF_MASK_HI 4'h8
`define TCW_OFF_STATUS 4'hc

// Configuration word layout
`define TCW_CFG_BITS 9
`define TCW_CFG_CLK_SEL_LSB 0
`define TCW_CFG_CLK_SEL_BITS 3
`define TCW_CFG_CLK_INV 3
`define TCW_CFG_CE_SEL_LSB 4
`define TCW_CFG_CE_SEL_BITS 2
`define TCW_CFG_CE_INV 6
`define TCW_CFG_OUT_REG 7
`define TCW_CFG_LRST_INV 8

// Registered outputs, dedicated clock, write-enable qualifier after reset
`define TCW_CFG_RESET 9'h080

// Status word layout
`define TCW_ST_MATCH 0
`define TCW_ST_MULTI 1
`define TCW_ST_ADDR_LSB 8

`endif

// >>> shared/tcw_pkg.sv
// Types shared by the ternary match block files
`default_nettype none

package tcw_pkg;

    // Register clock source choices
    typedef enum logic [2:0] {
        TCW_CLK_DEDICATED,
        TCW_CLK_GLOBAL0,
        TCW_CLK_GLOBAL1,
        TCW_CLK_GLOBAL2,
        TCW_CLK_GLOBAL3
    } tcw_clk_src_e;

    // Register clock-enable source choices
    typedef enum logic [1:0] {
        TCW_CE_WRITE_EN,
        TCW_CE_GLOBAL1,
        TCW_CE_GLOBAL2
    } tcw_ce_src_e;

    // Avalon slave answer sequencer
    typedef enum logic {
        TCW_BUS_IDLE,
        TCW_BUS_ANSWER
    } tcw_bus_e;

endpackage : tcw_pkg

`default_nettype wire

// >>> core/tcw_array.sv
// Ternary entry store with parallel compare and registered match vector
`default_nettype none
`include "tcw_regs.svh"

module tcw_array
    import tcw_pkg::*;
#(
    parameter int ENTRIES = `TCW_ENTRIES,
    parameter int WIDTH = `TCW_WIDTH,
    parameter int AW = $clog2(ENTRIES)
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_dont_care,
    input wire logic mask_enable,
    input wire logic [WIDTH-1:0] mask,
    input wire logic [WIDTH-1:0] key,
    output logic [ENTRIES-1:0] match_vec
);

    typedef struct packed {
        logic [ENTRIES-1:0][WIDTH-1:0] value;
        logic [ENTRIES-1:0][WIDTH-1:0] care;
        logic [ENTRIES-1:0] valid;
        logic [ENTRIES-1:0] match;
    } tcw_arr_s;

    tcw_arr_s st_r;
    tcw_arr_s st_nxt;
    logic [WIDTH-1:0] keep;
    logic [WIDTH-1:0] old_word;

    // Mask bits set to 1 protect stored bits and drop out of the compare
    assign keep = mask_enable ? mask : '0;
    assign old_word = st_r.value[wr_addr];
    assign match_vec = st_r.match;

    // Update port and full parallel compare
    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            if (wr_dont_care) begin
                // Ones in the data mark positions that stop caring
                st_nxt.care[wr_addr] = (st_r.care[wr_addr] & keep) | (~wr_data & ~keep);
            end else begin
                st_nxt.value[wr_addr] = (st_r.value[wr_addr] & keep) | (wr_data & ~keep);
                st_nxt.care[wr_addr] = st_r.care[wr_addr] | ~keep;
            end
            st_nxt.valid[wr_addr] = 1'b1;
        end
        // Compare sees the contents before a same-cycle update
        for (int i = 0; i < ENTRIES; i++) begin
            st_nxt.match[i] = st_r.valid[i] && (((st_r.value[i] ^ key) & st_r.care[i] & ~keep) == '0);
        end
    end

    // Contents are not cleared; only the valid and match bits, so never-written entries never hit
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r.valid <= '0;
            st_r.match <= '0;
        end else if (clock_enable) begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_update_stores: assert property (
        clock_enable && wr_en && !mask_enable && !wr_dont_care |=> st_r.value[$past(wr_addr)] == $past(wr_data))
        else $error("unmasked update did not store the data word");

    a_masked_bits_kept: assert property (
        clock_enable && wr_en && mask_enable && !wr_dont_care
        |=> ((st_r.value[$past(wr_addr)] ^ $past(old_word)) & $past(mask)) == '0)
        else $error("masked update changed a protected bit");

    a_masked_compare: assert property (
        clock_enable && mask_enable && st_r.valid[0] && (((st_r.value[0] ^ key) & st_r.care[0] & ~mask) == '0)
        |=> st_r.match[0])
        else $error("masked compare missed entry zero");

endmodule : tcw_array

`default_nettype wire

// >>> verif/tcw_fabric_model.sv
// Fabric-side user logic model that drives the match port of the ternary block
`default_nettype none

module tcw_fabric_model
    import tcw_pkg::*;
#(
    parameter int WIDTH = 48,
    parameter int AW = 7
) (
    input wire logic clock,
    output logic dedicated_clock,
    output logic [3:0] global_clock_set,
    output logic [WIDTH-1:0] write_data,
    output logic [AW-1:0] write_address,
    output logic write_enable,
    output logic write_chip_select,
    output logic write_dont_care,
    output logic mask_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pol; // Idle level of every clock source

    // Quiet lines at time zero
    initial begin
        pol = 1'b0;
        dedicated_clock = 1'b0;
        global_clock_set = 4'h0;
        write_data = '0;
        write_address = '0;
        write_enable = 1'b0;
        write_chip_select = 1'b0;
        write_dont_care = 1'b0;
        mask_enable = 1'b0;
    end

    // Source 0 is the dedicated clock, 1 to 4 the globals
    task automatic drive_src(input int s, input logic v);
        if (s == 0) dedicated_clock <= v;
        else global_clock_set[s-1] <= v;
    endtask : drive_src

    // Idle level follows the inversion chosen in the block
    task automatic set_pol(input logic p);
        @(posedge clock);
        pol = p;
        dedicated_clock <= p;
        global_clock_set <= {4{p}};
    endtask : set_pol

    // One operation: controls set up a cycle early, one active edge, then released
    task automatic op(input int s, input logic we, input logic cs, input logic dc, input logic me,
                      input logic [AW-1:0] a, input logic [WIDTH-1:0] d);
        @(posedge clock);
        write_data <= d;
        write_address <= a;
        write_enable <= we;
        write_chip_select <= cs;
        write_dont_care <= dc;
        mask_enable <= me;
        @(posedge clock);
        drive_src(s, !pol);
        repeat (2) @(posedge clock);
        drive_src(s, pol);
        // Mask enable held past the edge, released only now
        mask_enable <= 1'b0;
        write_enable <= 1'b0;
        write_chip_select <= 1'b0;
        write_dont_care <= 1'b0;
        write_data <= ~d; // Released lines show no stale value
        repeat (4) @(posedge clock);
    endtask : op
endmodule : tcw_fabric_model

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the ternary match block: bus accesses and match-port operations
`default_nettype none
`include "tcw_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module testbench
    import tcw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [47:0] KA = 48'h1234_5678_9abc;
    localparam logic [47:0] KB = 48'h0fed_cba9_8765;
    localparam logic [47:0] KC = 48'h1111_2222_3333;
    localparam logic [47:0] KD = 48'h0a0b_0c0d_0e0f;

    logic clock, reset, clock_enable, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable, global_clock_set;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic dedicated_clock, global_reset, local_reset, write_enable, write_chip_select;
    logic write_dont_care, mask_enable, match_flag, multi_match_flag;
    logic [47:0] write_data;
    logic [6:0] write_address, match_address;
    int err_count, check_count;

    tcw_top tcw_top_i (.clock(clock), .reset(reset), .clock_enable(clock_enable),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dedicated_clock(dedicated_clock),
        .global_clock_set(global_clock_set), .global_reset(global_reset), .local_reset(local_reset),
        .write_data(write_data), .write_address(write_address), .write_enable(write_enable),
        .write_chip_select(write_chip_select), .write_dont_care(write_dont_care),
        .mask_enable(mask_enable), .match_address(match_address), .match_flag(match_flag),
        .multi_match_flag(multi_match_flag));

    tcw_fabric_model tcw_fabric_model_i (.clock(clock), .dedicated_clock(dedicated_clock),
        .global_clock_set(global_clock_set), .write_data(write_data), .write_address(write_address),
        .write_enable(write_enable), .write_chip_select(write_chip_select),
        .write_dont_care(write_dont_care), .mask_enable(mask_enable));

    // 125 MHz system clock
    always #4 clock = ~clock;

    // Verdict and end of run
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    // One Avalon access, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            finish_test();
        end
    endtask : bus

    task automatic cfg(input logic [8:0] v);
        bus(1'b1, `TCW_OFF_CONFIG, {23'h0, v}, 4'hf);
    endtask : cfg

    // Entry update through the dedicated clock
    task automatic put(input logic [6:0] a, input logic [47:0] d, input logic me, input logic dc);
        tcw_fabric_model_i.op(0, 1'b1, 1'b1, dc, me, a, d);
    endtask : put

    // Compare on source s, then check both flags, and the match address when a hit is expected
    task automatic look(input int s, input logic we, input logic [47:0] k, input logic me,
                        input logic f, input logic m, input logic [6:0] a);
        tcw_fabric_model_i.op(s, we, 1'b0, 1'b0, me, 7'h00, k);
        `CHK("match_flag", f, match_flag)
        `CHK("multi_match_flag", m, multi_match_flag)
        if (f) `CHK("match_address", a, match_address)
    endtask : look

    // Watchdog against a hang anywhere
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        int i;
        int s;
        clock = 1'b0;
        reset = 1'b1;
        clock_enable = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        global_reset = 1'b0;
        local_reset = 1'b0;
        err_count = 0;
        check_count = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        // Reset values, byte lanes, unmapped offset
        bus(1'b0, `TCW_OFF_CONFIG, 32'h0, 4'hf);
        `CHK("config", 32'h0000_0080, rd)
        bus(1'b0, `TCW_OFF_STATUS, 32'h0, 4'hf);
        `CHK("status", 32'h0, rd)
        bus(1'b1, `TCW_OFF_MASK_LO, 32'haabb_ccff, 4'h1);
        bus(1'b0, `TCW_OFF_MASK_LO, 32'h0, 4'hf);
        `CHK("mask_lo", 32'h0000_00ff, rd)
        bus(1'b1, 4'h2, 32'hffff_ffff, 4'hf);
        bus(1'b0, 4'h2, 32'h0, 4'hf);
        `CHK("unmapped", 32'h0, rd)
        // Combinational outputs: update, lowest address, multiple hits
        cfg(9'h000);
        put(7'h05, KA, 1'b0, 1'b0);
        put(7'h09, KA, 1'b0, 1'b0);
        put(7'h03, KB, 1'b0, 1'b0);
        look(0, 1'b1, KA, 1'b0, 1'b1, 1'b1, 7'h05);
        bus(1'b1, `TCW_OFF_STATUS, 32'hffff_ffff, 4'hf);
        bus(1'b0, `TCW_OFF_STATUS, 32'h0, 4'hf);
        `CHK("status", 32'h0000_0503, rd)
        look(0, 1'b1, KB, 1'b0, 1'b1, 1'b0, 7'h03);
        look(0, 1'b1, KC, 1'b0, 1'b0, 1'b0, 7'h00);
        // Masking on compare and update, don't-care write
        look(0, 1'b1, KA ^ 48'h11, 1'b1, 1'b1, 1'b1, 7'h05);
        look(0, 1'b1, KA ^ 48'h11, 1'b0, 1'b0, 1'b0, 7'h00);
        // Entry zero hit only while the mask hides the low byte
        put(7'h00, KD, 1'b0, 1'b0);
        look(0, 1'b1, KD ^ 48'h3c, 1'b1, 1'b1, 1'b0, 7'h00);
        put(7'h09, KC, 1'b1, 1'b0);
        look(0, 1'b1, KA, 1'b0, 1'b1, 1'b0, 7'h05);
        look(0, 1'b1, 48'h1111_2222_33bc, 1'b0, 1'b1, 1'b0, 7'h09);
        put(7'h03, 48'hf, 1'b0, 1'b1);
        look(0, 1'b1, KB ^ 48'h5, 1'b0, 1'b1, 1'b0, 7'h03);
        // Every clock source, plain and inverted; an idle source must not capture
        for (i = 0; i < 10; i++) begin
            s = i % 5;
            cfg({5'h00, i >= 5, s[2:0]});
            tcw_fabric_model_i.set_pol(i >= 5);
            look(s, 1'b1, i[0] ? KA : KB, 1'b0, 1'b1, 1'b0, i[0] ? 7'h05 : 7'h03);
            tcw_fabric_model_i.op((s + 1) % 5, 1'b1, 1'b0, 1'b0, 1'b0, 7'h00, i[0] ? KB : KA);
            `CHK("match_address", i[0] ? 7'h05 : 7'h03, match_address)
        end
        cfg(9'h000);
        tcw_fabric_model_i.set_pol(1'b0);
        // Enable from an inverted global, then a global held off
        cfg(9'h050);
        look(0, 1'b0, KB, 1'b0, 1'b1, 1'b0, 7'h03);
        cfg(9'h020);
        tcw_fabric_model_i.op(0, 1'b1, 1'b0, 1'b0, 1'b0, 7'h00, KA);
        `CHK("match_address", 7'h03, match_address)
        // Registered outputs lag one qualified edge behind the capture
        cfg(9'h000);
        cfg(9'h080);
        tcw_fabric_model_i.op(0, 1'b1, 1'b0, 1'b0, 1'b0, 7'h00, KA);
        tcw_fabric_model_i.op(0, 1'b1, 1'b0, 1'b0, 1'b0, 7'h00, KB);
        `CHK("match_address", 7'h05, match_address)
        `CHK("multi_match_flag", 1'b0, multi_match_flag)
        // Clock enable low freezes everything; a free-running block would load entry 3 here
        clock_enable <= 1'b0;
        tcw_fabric_model_i.op(0, 1'b1, 1'b0, 1'b0, 1'b0, 7'h00, KA);
        clock_enable <= 1'b1;
        `CHK("match_address", 7'h05, match_address)
        // Shared reset from global, local, and inverted local
        cfg(9'h000);
        look(0, 1'b1, KA, 1'b0, 1'b1, 1'b0, 7'h05);
        global_reset <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK("match_flag", 1'b0, match_flag)
        `CHK("match_address", 7'h00, match_address)
        global_reset <= 1'b0;
        look(0, 1'b1, KA, 1'b0, 1'b1, 1'b0, 7'h05);
        local_reset <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK("match_flag", 1'b0, match_flag)
        local_reset <= 1'b0;
        // Hit first, so the inverted local reset has something to clear
        look(0, 1'b1, KA, 1'b0, 1'b1, 1'b0, 7'h05);
        cfg(9'h100);
        repeat (3) @(posedge clock);
        `CHK("match_flag", 1'b0, match_flag)
        local_reset <= 1'b1;
        look(0, 1'b1, KA, 1'b0, 1'b1, 1'b0, 7'h05);
        finish_test();
    end
endmodule : testbench

`default_nettype wire
